// *** csp_pkg.sv ***
package csp_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CSP_A_W    = 17;
    localparam int CSP_D_W    = 16;
    localparam int CSP_CAD_W  = 32;
    localparam int CSP_SYNC_W = 33;
    localparam int CSP_DIV_W  = 8;

    // ------------------------------------------------------------------
    // Pin positions within the address and data groups
    // ------------------------------------------------------------------
    localparam int CSP_A_CCLK  = 16;
    localparam int CSP_A_IRDY  = 15;
    localparam int CSP_A_PERR  = 14;
    localparam int CSP_A_PAR   = 13;
    localparam int CSP_A_CBE2  = 12;
    localparam int CSP_A_CBE1  = 8;
    localparam int CSP_D_RSV_H = 14;
    localparam int CSP_D_RSV_L = 2;
    localparam int CSP_OE_CAD  = 11;

    // Positions inside the synchroniser word
    localparam int CSP_SY_A  = 0;
    localparam int CSP_SY_D  = 16;
    localparam int CSP_SY_OE = 32;

    // ------------------------------------------------------------------
    // Timing: socket clock half period in system clocks, less one
    // ------------------------------------------------------------------
    localparam int                   CSP_SYS_CLK_MHZ = 250;
    localparam int                   CSP_CCLK_MHZ    = 25;
    localparam logic [CSP_DIV_W-1:0] CSP_CCLK_HALF   =
        CSP_DIV_W'(CSP_SYS_CLK_MHZ / (2 * CSP_CCLK_MHZ) - 1);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CSP_A_W-1:0]    CSP_A_OE_RST = 17'h1ffff;
    localparam logic [CSP_D_W-1:0]    CSP_D_RST    = 16'h0000;
    localparam logic [CSP_CAD_W-1:0]  CSP_CAD_RST  = 32'h0000_0000;
    localparam logic [CSP_SYNC_W-1:0] CSP_SYNC_RST = 33'h1_ffff_ffff;

endpackage

// *** csp_pin_sync.sv ***
`timescale 1ns/1ps
module csp_pin_sync (
    input  wire logic                           sys_clk_in,
    input  wire logic                           rst_b_in,
    input  wire logic [csp_pkg::CSP_SYNC_W-1:0] pin_in,
    output logic      [csp_pkg::CSP_SYNC_W-1:0] pin_out
);
    import csp_pkg::*;

    typedef struct packed {
        logic [CSP_SYNC_W-1:0] s1;
        logic [CSP_SYNC_W-1:0] s2;
        logic [CSP_SYNC_W-1:0] s3;
        logic [CSP_SYNC_W-1:0] q;
    } csp_sync_t;

    csp_sync_t st_r;
    csp_sync_t st_nxt;

    // ------------------------------------------------------------------
    // Three stages; a bit moves once stages two and three agree
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q  = (~(st_r.s2 ^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.q);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= '{CSP_SYNC_RST, CSP_SYNC_RST, CSP_SYNC_RST, CSP_SYNC_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.q;

endmodule

// *** csp_socket_pins.sv ***
`timescale 1ns/1ps
// Overview of operation
// - 16-bit memory read drives output-enable low
// - 16-bit memory write drives write-enable low
// - 16-bit mode drives card address 15:0
// - 16-bit data pins form bidirectional data bus
// - CardBus: address 15 pin is initiator ready
// - CardBus: address 14 pin is parity error
// - CardBus: address 13 pin is parity
// - CardBus: address 12, 8 carry byte enables
// - CardBus: address 11,10,9 carry lanes 12,9,14
// - CardBus: address 7..0 carry lanes 18,20..26
// - CardBus: data 15 pin is lane 8
// - CardBus: data 13..3 carry listed lanes
// - CardBus: data 1, 0 carry lanes 29, 27
// - CardBus: data 14 and 2 left unused
// - CardBus: output-enable pin is lane 11
// - CardBus: write-enable pin is bus grant
// - CardBus: address 16 pin supplies card clock
module csp_socket_pins (
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_b_in,
    // Mode from card-type detection
    input  wire logic                          cardbus_mode_in,
    // 16-bit engine side
    input  wire logic [15:0]                   mem_addr_in,
    input  wire logic [csp_pkg::CSP_D_W-1:0]   mem_wr_data_in,
    input  wire logic                          mem_rd_in,
    input  wire logic                          mem_wr_in,
    output logic      [csp_pkg::CSP_D_W-1:0]   mem_rd_data_out,
    // CardBus engine side
    input  wire logic [csp_pkg::CSP_CAD_W-1:0] cb_ad_in,
    input  wire logic                          cb_ad_oe_in,
    output logic      [csp_pkg::CSP_CAD_W-1:0] cb_ad_out,
    input  wire logic                          cb_irdy_b_in,
    input  wire logic                          cb_irdy_oe_in,
    output logic                               cb_irdy_b_out,
    input  wire logic                          cb_perr_b_in,
    input  wire logic                          cb_perr_oe_in,
    output logic                               cb_perr_b_out,
    input  wire logic                          cb_par_in,
    input  wire logic                          cb_par_oe_in,
    output logic                               cb_par_out,
    input  wire logic [1:0]                    cb_cbe_b_in,
    input  wire logic                          cb_cbe_oe_in,
    output logic      [1:0]                    cb_cbe_b_out,
    input  wire logic                          cb_gnt_b_in,
    input  wire logic                          cb_clk_run_in,
    // Socket pins: address group
    input  wire logic [csp_pkg::CSP_A_W-1:0]   sk_a_in,
    output logic      [csp_pkg::CSP_A_W-1:0]   sk_a_out,
    output logic      [csp_pkg::CSP_A_W-1:0]   sk_a_oe_out,
    // Socket pins: data group
    input  wire logic [csp_pkg::CSP_D_W-1:0]   sk_d_in,
    output logic      [csp_pkg::CSP_D_W-1:0]   sk_d_out,
    output logic      [csp_pkg::CSP_D_W-1:0]   sk_d_oe_out,
    // Socket pins: read and write strobes
    input  wire logic                          sk_oe_in,
    output logic                               sk_oe_out,
    output logic                               sk_oe_oe_out,
    output logic                               sk_we_out,
    output logic                               sk_we_oe_out
);
    import csp_pkg::*;

    // ------------------------------------------------------------------
    // Lane maps
    // ------------------------------------------------------------------

    // Lane of a data pin in CardBus mode; bit 5 set means no function
    function automatic logic [5:0] csp_d_cad(input logic [3:0] i);
        logic [5:0] r;
        r = 6'h20;
        unique case (i)
            4'hf: r = 6'h08;
            4'hd: r = 6'h06;
            4'hc: r = 6'h04;
            4'hb: r = 6'h02;
            4'ha: r = 6'h1f;
            4'h9: r = 6'h1e;
            4'h8: r = 6'h1c;
            4'h7: r = 6'h07;
            4'h6: r = 6'h05;
            4'h5: r = 6'h03;
            4'h4: r = 6'h01;
            4'h3: r = 6'h00;
            4'h1: r = 6'h1d;
            4'h0: r = 6'h1b;
            default: r = 6'h20;
        endcase
        return r;
    endfunction

    // Lane of an address pin in CardBus mode; bit 5 set means not a lane
    function automatic logic [5:0] csp_a_cad(input logic [3:0] i);
        logic [5:0] r;
        r = 6'h20;
        unique case (i)
            4'hb: r = 6'h0c;
            4'ha: r = 6'h09;
            4'h9: r = 6'h0e;
            4'h7: r = 6'h12;
            4'h6: r = 6'h14;
            4'h5: r = 6'h15;
            4'h4: r = 6'h16;
            4'h3: r = 6'h17;
            4'h2: r = 6'h18;
            4'h1: r = 6'h19;
            4'h0: r = 6'h1a;
            default: r = 6'h20;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CSP_A_W-1:0]   a_o;
        logic [CSP_A_W-1:0]   a_oe;
        logic [CSP_D_W-1:0]   d_o;
        logic [CSP_D_W-1:0]   d_oe;
        logic                 oe_o;
        logic                 oe_oe;
        logic                 we_o;
        logic                 we_oe;
        logic [CSP_D_W-1:0]   rd_data;
        logic [CSP_CAD_W-1:0] cad_in;
        logic                 irdy_in;
        logic                 perr_in;
        logic                 par_in;
        logic [1:0]           cbe_in;
        logic                 cclk;
        logic [CSP_DIV_W-1:0] div_cnt;
    } csp_state_t;

    csp_state_t            st_r;
    csp_state_t            st_nxt;
    logic [CSP_SYNC_W-1:0] pin_sync;
    logic [CSP_A_W-2:0]    a_pin;
    logic [CSP_D_W-1:0]    d_pin;
    logic                  oe_pin;

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    csp_pin_sync u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .pin_in     ({sk_oe_in, sk_d_in, sk_a_in[CSP_A_W-2:0]}),
        .pin_out    (pin_sync)
    );

    assign a_pin  = pin_sync[CSP_SY_A +: CSP_A_W-1];
    assign d_pin  = pin_sync[CSP_SY_D +: CSP_D_W];
    assign oe_pin = pin_sync[CSP_SY_OE];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [5:0] lane;
        lane   = 6'h00;
        st_nxt = st_r;

        // Socket clock divider; only runs in CardBus mode
        if (cardbus_mode_in && cb_clk_run_in) begin
            if (st_r.div_cnt == CSP_CCLK_HALF) begin
                st_nxt.div_cnt = '0;
                st_nxt.cclk    = ~st_r.cclk;
            end else begin
                st_nxt.div_cnt = CSP_DIV_W'(st_r.div_cnt + 1'b1);
            end
        end else begin
            st_nxt.div_cnt = '0;
            st_nxt.cclk    = 1'b0;
        end

        if (!cardbus_mode_in) begin
            // 16-bit function set
            st_nxt.a_o  = {1'b0, mem_addr_in};
            st_nxt.a_oe = CSP_A_OE_RST;
            st_nxt.d_o  = mem_wr_data_in;
            st_nxt.d_oe = {CSP_D_W{mem_wr_in & ~mem_rd_in}};
            st_nxt.oe_o  = ~(mem_rd_in & ~mem_wr_in);
            st_nxt.oe_oe = 1'b1;
            st_nxt.we_o  = ~(mem_wr_in & ~mem_rd_in);
            st_nxt.we_oe = 1'b1;
            st_nxt.rd_data = d_pin;
            st_nxt.cad_in  = CSP_CAD_RST;
            st_nxt.irdy_in = 1'b1;
            st_nxt.perr_in = 1'b1;
            st_nxt.par_in  = 1'b0;
            st_nxt.cbe_in  = 2'h3;
        end else begin
            // CardBus function set
            st_nxt.rd_data = CSP_D_RST;
            st_nxt.cad_in  = CSP_CAD_RST;
            st_nxt.a_o     = '0;
            st_nxt.a_oe    = '0;
            st_nxt.d_o     = '0;
            st_nxt.d_oe    = '0;

            st_nxt.a_o[CSP_A_CCLK]  = st_r.cclk;
            st_nxt.a_oe[CSP_A_CCLK] = 1'b1;

            st_nxt.a_o[CSP_A_IRDY]  = cb_irdy_b_in;
            st_nxt.a_oe[CSP_A_IRDY] = cb_irdy_oe_in;
            st_nxt.irdy_in          = a_pin[CSP_A_IRDY];

            st_nxt.a_o[CSP_A_PERR]  = cb_perr_b_in;
            st_nxt.a_oe[CSP_A_PERR] = cb_perr_oe_in;
            st_nxt.perr_in          = a_pin[CSP_A_PERR];

            st_nxt.a_o[CSP_A_PAR]   = cb_par_in;
            st_nxt.a_oe[CSP_A_PAR]  = cb_par_oe_in;
            st_nxt.par_in           = a_pin[CSP_A_PAR];

            st_nxt.a_o[CSP_A_CBE2]  = cb_cbe_b_in[1];
            st_nxt.a_oe[CSP_A_CBE2] = cb_cbe_oe_in;
            st_nxt.a_o[CSP_A_CBE1]  = cb_cbe_b_in[0];
            st_nxt.a_oe[CSP_A_CBE1] = cb_cbe_oe_in;
            st_nxt.cbe_in = {a_pin[CSP_A_CBE2], a_pin[CSP_A_CBE1]};

            // Address pins carrying data lanes
            for (int i = 0; i < CSP_A_W - 1; i++) begin
                lane = csp_a_cad(4'(i));
                if (!lane[5]) begin
                    st_nxt.a_o[i]          = cb_ad_in[lane[4:0]];
                    st_nxt.a_oe[i]         = cb_ad_oe_in;
                    st_nxt.cad_in[lane[4:0]] = a_pin[i];
                end
            end

            // Data pins carrying data lanes; unused pins stay undriven
            for (int i = 0; i < CSP_D_W; i++) begin
                lane = csp_d_cad(4'(i));
                if (!lane[5]) begin
                    st_nxt.d_o[i]          = cb_ad_in[lane[4:0]];
                    st_nxt.d_oe[i]         = cb_ad_oe_in;
                    st_nxt.cad_in[lane[4:0]] = d_pin[i];
                end
            end
            st_nxt.d_oe[CSP_D_RSV_H] = 1'b0;
            st_nxt.d_oe[CSP_D_RSV_L] = 1'b0;

            st_nxt.oe_o                = cb_ad_in[CSP_OE_CAD];
            st_nxt.oe_oe               = cb_ad_oe_in;
            st_nxt.cad_in[CSP_OE_CAD]  = oe_pin;

            st_nxt.we_o  = cb_gnt_b_in;
            st_nxt.we_oe = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r.a_o     <= '0;
            st_r.a_oe    <= CSP_A_OE_RST;
            st_r.d_o     <= CSP_D_RST;
            st_r.d_oe    <= CSP_D_RST;
            st_r.oe_o    <= 1'b1;
            st_r.oe_oe   <= 1'b1;
            st_r.we_o    <= 1'b1;
            st_r.we_oe   <= 1'b1;
            st_r.rd_data <= CSP_D_RST;
            st_r.cad_in  <= CSP_CAD_RST;
            st_r.irdy_in <= 1'b1;
            st_r.perr_in <= 1'b1;
            st_r.par_in  <= 1'b0;
            st_r.cbe_in  <= 2'h3;
            st_r.cclk    <= 1'b0;
            st_r.div_cnt <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sk_a_out        = st_r.a_o;
    assign sk_a_oe_out     = st_r.a_oe;
    assign sk_d_out        = st_r.d_o;
    assign sk_d_oe_out     = st_r.d_oe;
    assign sk_oe_out       = st_r.oe_o;
    assign sk_oe_oe_out    = st_r.oe_oe;
    assign sk_we_out       = st_r.we_o;
    assign sk_we_oe_out    = st_r.we_oe;
    assign mem_rd_data_out = st_r.rd_data;
    assign cb_ad_out       = st_r.cad_in;
    assign cb_irdy_b_out   = st_r.irdy_in;
    assign cb_perr_b_out   = st_r.perr_in;
    assign cb_par_out      = st_r.par_in;
    assign cb_cbe_b_out    = st_r.cbe_in;

endmodule

// *** csp_socket_pins_props.sv ***
`timescale 1ns/1ps
module csp_socket_pins_chk (
    input wire logic        sys_clk_in,
    input wire logic        rst_b_in,
    input wire logic        cardbus_mode_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic [15:0] mem_wr_data_in,
    input wire logic        mem_rd_in,
    input wire logic        mem_wr_in,
    input wire logic [31:0] cb_ad_in,
    input wire logic        cb_ad_oe_in,
    input wire logic        cb_irdy_b_in,
    input wire logic        cb_irdy_oe_in,
    input wire logic        cb_perr_b_in,
    input wire logic        cb_perr_oe_in,
    input wire logic        cb_par_in,
    input wire logic        cb_par_oe_in,
    input wire logic [1:0]  cb_cbe_b_in,
    input wire logic        cb_cbe_oe_in,
    input wire logic        cb_gnt_b_in,
    input wire logic        cb_clk_run_in,
    input wire logic [16:0] sk_a_out,
    input wire logic [15:0] sk_d_out,
    input wire logic [15:0] sk_d_oe_out,
    input wire logic        sk_oe_out,
    input wire logic        sk_we_out,
    input wire logic        sk_we_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic        rd16, wr16, ctl_en, cb;
    logic [4:0]  ctl_v;
    logic [10:0] a_lane;
    logic [14:0] d_lane;
    assign cb     = cardbus_mode_in;
    assign rd16   = !cb && mem_rd_in && !mem_wr_in;
    assign wr16   = !cb && mem_wr_in && !mem_rd_in;
    assign ctl_en = cb && cb_irdy_oe_in && cb_perr_oe_in && cb_par_oe_in && cb_cbe_oe_in;
    assign ctl_v  = {cb_irdy_b_in, cb_perr_b_in, cb_par_in, cb_cbe_b_in};
    assign a_lane = {cb_ad_in[12], cb_ad_in[9], cb_ad_in[14], cb_ad_in[18], cb_ad_in[20],
                     cb_ad_in[21], cb_ad_in[22], cb_ad_in[23], cb_ad_in[24], cb_ad_in[25],
                     cb_ad_in[26]};
    assign d_lane = {cb_ad_in[8], cb_ad_in[6], cb_ad_in[4], cb_ad_in[2], cb_ad_in[31],
                     cb_ad_in[30], cb_ad_in[28], cb_ad_in[7], cb_ad_in[5], cb_ad_in[3],
                     cb_ad_in[1], cb_ad_in[0], cb_ad_in[29], cb_ad_in[27], cb_ad_in[11]};
    rd_strobe_a: assert property (rd16 |=> !sk_oe_out && sk_d_oe_out == 16'h0000)
        else $error("read strobe wrong");
    wr_strobe_a: assert property (wr16 |=> !sk_we_out && sk_d_out == $past(mem_wr_data_in))
        else $error("write strobe or data wrong");
    addr_pins_a: assert property (!cb |=> sk_a_out[15:0] == $past(mem_addr_in))
        else $error("address pins wrong");
    idle_strobe_a: assert property (!cb && mem_rd_in && mem_wr_in |=> sk_oe_out && sk_we_out)
        else $error("strobes not idle");
    ctl_pins_a: assert property (ctl_en |=> {sk_a_out[15:12], sk_a_out[8]} == $past(ctl_v))
        else $error("control pins wrong");
    cad_addr_a: assert property (cb |=> {sk_a_out[11:9], sk_a_out[7:0]} == $past(a_lane))
        else $error("address lanes wrong");
    cad_data_a: assert property (cb |=> {sk_d_out[15], sk_d_out[13:3], sk_d_out[1:0],
        sk_oe_out} == $past(d_lane))
        else $error("data lanes wrong");
    data_oe_a: assert property (cb |=> sk_d_oe_out == ($past(cb_ad_oe_in) ? 16'hbffb : 16'h0))
        else $error("data enables wrong");
    grant_pin_a: assert property (cb |=> sk_we_out == $past(cb_gnt_b_in) && sk_we_oe_out)
        else $error("grant pin wrong");
    card_clk_a: assert property ((cb && cb_clk_run_in) [*8] |-> sk_a_out[16] != $past(sk_a_out[16], 5))
        else $error("card clock period wrong");
endmodule
bind csp_socket_pins csp_socket_pins_chk u_chk (.sys_clk_in, .rst_b_in, .cardbus_mode_in,
    .mem_addr_in, .mem_wr_data_in, .mem_rd_in, .mem_wr_in, .cb_ad_in, .cb_ad_oe_in,
    .cb_irdy_b_in, .cb_irdy_oe_in, .cb_perr_b_in, .cb_perr_oe_in, .cb_par_in, .cb_par_oe_in,
    .cb_cbe_b_in, .cb_cbe_oe_in, .cb_gnt_b_in, .cb_clk_run_in, .sk_a_out, .sk_d_out,
    .sk_d_oe_out, .sk_oe_out, .sk_we_out, .sk_we_oe_out);

// *** csp_card_model.sv ***
`timescale 1ns/1ps
module csp_card_model (
    input  wire logic        sys_clk_in,
    input  wire logic        cb_card_in,
    input  wire logic        drive_in,
    input  wire logic [31:0] cad_in,
    input  wire logic [16:0] a_pin_in,
    input  wire logic [15:0] d_pin_in,
    input  wire logic        oe_pin_in,
    input  wire logic        we_pin_in,
    output logic      [16:0] a_out,
    output logic      [16:0] a_en_out,
    output logic      [15:0] d_out,
    output logic      [15:0] d_en_out,
    output logic             oe_out,
    output logic             oe_en_out
);
    logic [15:0] mem [16];
    logic        cb_drv;
    assign cb_drv    = cb_card_in && drive_in;
    assign a_out     = {5'h00, cad_in[12], cad_in[9], cad_in[14], 1'b0, cad_in[18], cad_in[20],
                        cad_in[21], cad_in[22], cad_in[23], cad_in[24], cad_in[25],
                        cad_in[26]};
    assign a_en_out  = cb_drv ? 17'h00eff : 17'h00000;
    assign d_out     = cb_card_in ? {cad_in[8], 1'b0, cad_in[6], cad_in[4], cad_in[2], cad_in[31],
                        cad_in[30], cad_in[28], cad_in[7], cad_in[5], cad_in[3], cad_in[1],
                        cad_in[0], 1'b0, cad_in[29], cad_in[27]}
                        : mem[a_pin_in[3:0]];
    // Answers a read only while the strobe is low
    assign d_en_out  = cb_card_in ? (drive_in ? 16'hbffb : 16'h0000)
                        : ((!oe_pin_in && we_pin_in) ? 16'hffff : 16'h0000);
    assign oe_out    = cad_in[11];
    assign oe_en_out = cb_drv;
    always @(posedge sys_clk_in) begin
        if (!cb_card_in && !we_pin_in && oe_pin_in) begin
            mem[a_pin_in[3:0]] <= d_pin_in;
        end
    end
endmodule

// *** csp_socket_pins_test.sv ***
`timescale 1ns/1ps
module csp_socket_pins_test;
    import csp_pkg::*;
    localparam logic [31:0] LANES = 32'hfff4_5bff;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        mode, rd, wr, ad_oe, irdy_b, irdy_oe, perr_b, perr_oe, par, par_oe;
    logic        cbe_oe, gnt_b, clk_run, card_drv, lv;
    logic [1:0]  cbe_b, cbe_o;
    logic [15:0] addr, wdata, rdata, d_o, d_oe, d_w, c_d, c_de, d_last = 16'h0;
    logic [31:0] ad, ad_o, cad;
    logic [16:0] a_o, a_oe, a_w, c_a, c_ae, a_last = 17'h0;
    logic        irdy_o, perr_o, par_o, oe_o, oe_oe, we_o, we_oe, oe_w, c_o, c_oe;
    logic        oe_last = 1'b0;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    always #2 clk = ~clk;
    // Released lines show the inverse of their last level
    assign a_w  = (a_oe & a_o) | (~a_oe & c_ae & c_a) | (~a_oe & ~c_ae & ~a_last);
    assign d_w  = (d_oe & d_o) | (~d_oe & c_de & c_d) | (~d_oe & ~c_de & ~d_last);
    assign oe_w = oe_oe ? oe_o : (c_oe ? c_o : ~oe_last);
    always @(posedge clk) begin
        a_last <= a_w;
        d_last <= d_w;
        oe_last <= oe_w;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            results;
        end
    end
    csp_socket_pins DUT (.sys_clk_in(clk), .rst_b_in(rst_b), .cardbus_mode_in(mode),
        .mem_addr_in(addr), .mem_wr_data_in(wdata), .mem_rd_in(rd), .mem_wr_in(wr),
        .mem_rd_data_out(rdata), .cb_ad_in(ad), .cb_ad_oe_in(ad_oe), .cb_ad_out(ad_o),
        .cb_irdy_b_in(irdy_b), .cb_irdy_oe_in(irdy_oe), .cb_irdy_b_out(irdy_o),
        .cb_perr_b_in(perr_b), .cb_perr_oe_in(perr_oe), .cb_perr_b_out(perr_o),
        .cb_par_in(par), .cb_par_oe_in(par_oe), .cb_par_out(par_o), .cb_cbe_b_in(cbe_b),
        .cb_cbe_oe_in(cbe_oe), .cb_cbe_b_out(cbe_o), .cb_gnt_b_in(gnt_b),
        .cb_clk_run_in(clk_run), .sk_a_in(a_w), .sk_a_out(a_o), .sk_a_oe_out(a_oe),
        .sk_d_in(d_w), .sk_d_out(d_o), .sk_d_oe_out(d_oe), .sk_oe_in(oe_w), .sk_oe_out(oe_o),
        .sk_oe_oe_out(oe_oe), .sk_we_out(we_o), .sk_we_oe_out(we_oe));
    csp_card_model u_card (.sys_clk_in(clk), .cb_card_in(mode), .drive_in(card_drv),
        .cad_in(cad), .a_pin_in(a_w), .d_pin_in(d_w), .oe_pin_in(oe_w), .we_pin_in(we_o),
        .a_out(c_a), .a_en_out(c_ae), .d_out(c_d), .d_en_out(c_de), .oe_out(c_o),
        .oe_en_out(c_oe));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset;
        @(negedge clk);
        rst_b = 1'b0;
        repeat (5) @(negedge clk);
        chk("reset pins", 32'h1ffff, a_oe);
        chk("reset strobe", 32'h1, oe_o);
        rst_b = 1'b1;
        @(negedge clk);
    endtask
    task automatic t_rw16(input logic [15:0] v);
        mode = 1'b0;
        addr = 16'h8c03;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        chk("we pin", 32'h0, we_o);
        chk("addr pins", 32'h8c03, a_o[15:0]);
        chk("data pins", {16'h0, v}, d_o);
        chk("data oe", 32'hffff, d_oe);
        wr = 1'b0;
        rd = 1'b1;
        @(negedge clk);
        chk("oe pin", 32'h0, oe_o);
        chk("read oe", 32'h0, d_oe);
        repeat (8) @(negedge clk);
        chk("read data", {16'h0, v}, rdata);
        wr = 1'b1;
        @(negedge clk);
        chk("both strobes", 32'h3, {oe_o, we_o});
        rd = 1'b0;
        wr = 1'b0;
    endtask
    task automatic t_cb_out(input logic [31:0] v);
        mode = 1'b1;
        {ad_oe, irdy_oe, perr_oe, par_oe, cbe_oe} = 5'h1f;
        ad = v;
        {gnt_b, cbe_b, par, perr_b, irdy_b} = v[5:0];
        @(negedge clk);
        chk("grant pin", v[5], we_o);
        chk("cb data oe", 32'hbffb, d_oe);
        repeat (8) @(negedge clk);
        chk("cad loop", v & LANES, ad_o);
        chk("ctl loop", v[4:0], {cbe_o, par_o, perr_o, irdy_o});
    endtask
    task automatic t_cb_in;
        {ad_oe, irdy_oe, perr_oe, par_oe, cbe_oe} = 5'h00;
        cad = 32'hdead_beef;
        card_drv = 1'b1;
        repeat (9) @(negedge clk);
        chk("cad from card", 32'hdead_beef & LANES, ad_o);
        chk("cb a oe", 32'h1_0000, a_oe);
        chk("oe pin oe", 32'h0, oe_oe);
        card_drv = 1'b0;
    endtask
    task automatic t_cclk;
        int n;
        clk_run = 1'b1;
        for (int k = 0; k < 2; k++) begin
            lv = a_o[16];
            n = 0;
            while (a_o[16] === lv && n < 20) begin
                @(negedge clk);
                n++;
            end
        end
        chk("cclk half period", 32'd5, n);
        repeat (10) @(negedge clk);
        clk_run = 1'b0;
        repeat (12) @(negedge clk);
        chk("cclk stopped", 32'h0, a_o[16]);
    endtask
    task automatic results;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        {mode, rd, wr, ad_oe, irdy_oe, perr_oe, par_oe, cbe_oe, par, clk_run, card_drv} = '0;
        {irdy_b, perr_b, gnt_b, cbe_b} = 5'h1f;
        {addr, wdata, ad, cad} = '0;
        do_reset;
        t_rw16(16'ha5c3);
        t_cb_out(32'h1234_5678);
        t_cb_out(32'hedcb_a987);
        t_cb_in;
        t_cclk;
        do_reset;
        t_rw16(16'h3c5a);
        results;
    end
endmodule
